/* File: verilog/cog_pipe_pkg.sv */
`default_nettype none
package cog_pipe_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 9;
    localparam int MEM_DEPTH = 512;
    // Instruction layout
    localparam int OP_HI = 31;
    localparam int OP_LO = 26;
    localparam int IMM_BIT = 25;
    localparam int WR_BIT = 24;
    localparam int DST_HI = 17;
    localparam int DST_LO = 9;
    localparam int SRC_HI = 8;
    localparam int SRC_LO = 0;
    localparam int OPF_LO = 23;
    // Reset values and timing
    localparam logic [ADDR_W-1:0] PC_RESET = 9'h000;
    localparam logic [3:0] HUB_PERIOD_M1 = 4'h0_F;
    localparam logic [3:0] HUB_CNT_RESET = 4'h0;
    localparam logic [2:0] HUB_HOLD = 3'h4;
    localparam logic [4:0] HUB_STALL_MAX = 5'h1_3;

    typedef enum logic [1:0] {PH_FETCH, PH_WRBACK, PH_SRC, PH_DST} phase_t;

    typedef enum logic [5:0] {
        OP_MOV, OP_ADD, OP_SUB, OP_AND, OP_OR,
        OP_MOVE_INTO_OPCODE_FIELD, OP_MOVE_INTO_SOURCE_FIELD, OP_MOVE_INTO_DESTINATION_FIELD,
        OP_JUMP_UNCONDITIONAL, OP_JUMP_WITH_LINK, OP_DECREMENT_BRANCH_NONZERO,
        OP_HUB_READ, OP_HUB_WRITE
    } op_t;

    typedef struct packed {
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } load_t;

    typedef struct packed {
        logic valid;
        logic we;
        logic [DATA_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } hub_req_t;
endpackage : cog_pipe_pkg
`default_nettype wire

/* File: verilog/cog_ram.sv */
`timescale 1ns/1ps
`default_nettype none
module cog_ram
    import cog_pipe_pkg::*;
(
    input wire logic clock_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    output logic [DATA_W-1:0] rdata_o
);
    logic [DATA_W-1:0] mem [MEM_DEPTH];

    // Read data is registered, so a read issued in one cycle is seen the next
    always_ff @(posedge clock_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end
endmodule : cog_ram
`default_nettype wire

/* File: verilog/cog_instruction_pipeline.sv */
`timescale 1ns/1ps
`default_nettype none
module cog_instruction_pipeline
    import cog_pipe_pkg::*;
#(
    parameter logic [3:0] CORE_SLOT = 4'h0
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire load_t load_i,
    input wire logic [DATA_W-1:0] hub_rdata_i,
    output hub_req_t hub_req_o,
    output logic [ADDR_W-1:0] pc_o
);
    function automatic logic [ADDR_W-1:0] src_field(input logic [DATA_W-1:0] w);
        src_field = w[SRC_HI:SRC_LO];
    endfunction : src_field

    function automatic logic [ADDR_W-1:0] dst_field(input logic [DATA_W-1:0] w);
        dst_field = w[DST_HI:DST_LO];
    endfunction : dst_field

    phase_t phase_q;
    logic [ADDR_W-1:0] pc_q, ir_pc_q, wr_addr_q;
    logic [DATA_W-1:0] ir_q, src_q, dest_q, res_q, mem_rdata, mem_wdata, alu_res, dest_val, src_val;
    logic valid_q, squash_q, wr_pend_q, hub_on_q, stall, mem_we, is_hub, is_jump, is_cond, taken, writes;
    logic [ADDR_W-1:0] mem_addr;
    logic [3:0] hub_cnt_q;
    logic [2:0] hub_left_q;
    logic [4:0] stall_cnt_q;
    op_t op;

    assign op = op_t'(ir_q[OP_HI:OP_LO]);
    assign is_hub = valid_q && (op == OP_HUB_READ || op == OP_HUB_WRITE);
    assign is_cond = op == OP_DECREMENT_BRANCH_NONZERO;
    assign is_jump = op == OP_JUMP_UNCONDITIONAL || op == OP_JUMP_WITH_LINK || is_cond;
    assign writes = ir_q[WR_BIT] && op != OP_JUMP_UNCONDITIONAL && op != OP_HUB_WRITE;
    // Execute is held in the fetch phase until the hub access has run out
    assign stall = phase_q == PH_FETCH && is_hub && !(hub_on_q && hub_left_q == 3'h1);

    // Source operand: immediate field or the word read in M+2, valid in M+3
    assign src_val = ir_q[IMM_BIT] ? {{(DATA_W-ADDR_W){1'b0}}, src_field(ir_q)} : mem_rdata;
    // The memory output changes during a stall, so the first cycle's read is kept
    assign dest_val = (stall_cnt_q == 5'h0_0) ? mem_rdata : dest_q;
    assign taken = (dest_val - 32'h0000_0001) != 32'h0000_0000;

    always_comb begin
        alu_res = dest_val;
        case (op)
            OP_MOV: alu_res = src_q;
            OP_ADD: alu_res = dest_val + src_q;
            OP_SUB: alu_res = dest_val - src_q;
            OP_AND: alu_res = dest_val & src_q;
            OP_OR: alu_res = dest_val | src_q;
            OP_MOVE_INTO_OPCODE_FIELD: alu_res = {src_q[ADDR_W-1:0], dest_val[OPF_LO-1:0]};
            OP_MOVE_INTO_SOURCE_FIELD: alu_res = {dest_val[DATA_W-1:ADDR_W], src_q[ADDR_W-1:0]};
            OP_MOVE_INTO_DESTINATION_FIELD: alu_res = {dest_val[DATA_W-1:DST_HI+1], src_q[ADDR_W-1:0],
                                                       dest_val[SRC_HI:0]};
            OP_JUMP_WITH_LINK: alu_res = {dest_val[DATA_W-1:ADDR_W], ADDR_W'(ir_pc_q + 9'h001)};
            OP_DECREMENT_BRANCH_NONZERO: alu_res = dest_val - 32'h0000_0001;
            OP_HUB_READ: alu_res = hub_rdata_i;
            default: alu_res = dest_val;
        endcase
    end

    // One port, one use per phase: fetch, write-back, source, destination
    always_comb begin
        mem_addr = pc_q;
        mem_we = 1'b0;
        mem_wdata = res_q;
        if (!run_i) begin
            mem_addr = load_i.addr;
            mem_we = load_i.we;
            mem_wdata = load_i.data;
        end else begin
            case (phase_q)
                PH_FETCH: mem_addr = pc_q;
                PH_WRBACK: begin
                    mem_addr = wr_addr_q;
                    mem_we = wr_pend_q;
                end
                PH_SRC: mem_addr = src_field(ir_q);
                PH_DST: mem_addr = dst_field(ir_q);
                default: mem_addr = pc_q;
            endcase
        end
    end

    cog_ram u_ram (
        .clock_i(clock_i),
        .we_i(mem_we),
        .addr_i(mem_addr),
        .wdata_i(mem_wdata),
        .rdata_o(mem_rdata)
    );

    // Phase sequencer: four clocks per slot unless the hub holds execute
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || !run_i) begin
            phase_q <= PH_FETCH;
        end else if (!stall) begin
            case (phase_q)
                PH_FETCH: phase_q <= PH_WRBACK;
                PH_WRBACK: phase_q <= PH_SRC;
                PH_SRC: phase_q <= PH_DST;
                PH_DST: phase_q <= PH_FETCH;
                default: phase_q <= PH_FETCH;
            endcase
        end
    end

    // Instruction register and program counter
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || !run_i) begin
            pc_q <= PC_RESET;
            ir_pc_q <= PC_RESET;
            ir_q <= 32'h0000_0000;
            valid_q <= 1'b0;
            squash_q <= 1'b0;
        end else begin
            case (phase_q)
                PH_WRBACK: begin
                    // Fetched before the previous result landed, so a fresh rewrite is missed
                    ir_q <= mem_rdata;
                    ir_pc_q <= pc_q;
                    valid_q <= !squash_q;
                    squash_q <= 1'b0;
                    pc_q <= ADDR_W'(pc_q + 9'h001);
                end
                PH_DST: begin
                    if (valid_q && is_jump) begin
                        pc_q <= src_val[ADDR_W-1:0];
                    end
                end
                PH_FETCH: begin
                    if (!stall && valid_q && is_cond && !taken) begin
                        // Rewind to the branch, so the bubble's own step lands on the fall-through word
                        pc_q <= ir_pc_q;
                        squash_q <= 1'b1;
                    end
                end
                default: pc_q <= pc_q;
            endcase
        end
    end

    // Operands and result
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || !run_i) begin
            src_q <= 32'h0000_0000;
            dest_q <= 32'h0000_0000;
            res_q <= 32'h0000_0000;
            wr_addr_q <= PC_RESET;
            wr_pend_q <= 1'b0;
        end else begin
            if (phase_q == PH_DST) begin
                src_q <= src_val;
            end
            if (phase_q == PH_FETCH) begin
                dest_q <= dest_val;
                if (!stall) begin
                    res_q <= alu_res;
                    wr_addr_q <= dst_field(ir_q);
                    wr_pend_q <= valid_q && writes;
                end
            end
            if (phase_q == PH_WRBACK) begin
                wr_pend_q <= 1'b0;
            end
        end
    end

    // Hub window and access
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            hub_cnt_q <= HUB_CNT_RESET;
        end else begin
            hub_cnt_q <= (hub_cnt_q == HUB_PERIOD_M1) ? HUB_CNT_RESET : hub_cnt_q + 4'h1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i || !run_i) begin
            hub_on_q <= 1'b0;
            hub_left_q <= 3'h0;
            stall_cnt_q <= 5'h0_0;
            hub_req_o <= '0;
        end else begin
            stall_cnt_q <= stall ? stall_cnt_q + 5'h0_1 : 5'h0_0;
            if (stall && !hub_on_q && hub_cnt_q == CORE_SLOT) begin
                hub_on_q <= 1'b1;
                hub_left_q <= HUB_HOLD;
                hub_req_o.valid <= 1'b1;
                hub_req_o.we <= op == OP_HUB_WRITE;
                hub_req_o.addr <= src_q;
                hub_req_o.wdata <= dest_val;
            end else if (hub_on_q) begin
                hub_left_q <= hub_left_q - 3'h1;
                if (hub_left_q == 3'h1) begin
                    hub_on_q <= 1'b0;
                    hub_req_o.valid <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pc_o <= PC_RESET;
        end else begin
            pc_o <= pc_q;
        end
    end

    a_fetch_at_m: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        run_i && phase_q == PH_FETCH |-> mem_addr == pc_q && !mem_we)
        else $error("fetch phase does not read the program counter");
    a_write_slot_only: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        run_i && mem_we |-> phase_q == PH_WRBACK)
        else $error("memory written outside the write-back phase");
    a_four_clock_slot: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        run_i && phase_q == PH_FETCH && !stall ##1 run_i [*4] |-> phase_q == PH_FETCH)
        else $error("slot did not last four clocks");
    a_imm_operand: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        run_i && phase_q == PH_DST && ir_q[IMM_BIT] ##1 run_i |-> src_q == {23'h00_0000, $past(ir_q[SRC_HI:SRC_LO])})
        else $error("immediate source not taken from the field");
    a_src_dst_reads: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        run_i && phase_q == PH_SRC |=> !run_i || mem_addr == ir_q[DST_HI:DST_LO])
        else $error("destination not read after source phase");
    a_hub_bound: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        stall_cnt_q <= HUB_STALL_MAX)
        else $error("hub stall longer than 19 cycles");
    a_hub_window: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $rose(hub_on_q) |-> $past(hub_cnt_q) == CORE_SLOT)
        else $error("hub access began outside own window");
    a_branch_squash: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        run_i && phase_q == PH_FETCH && !stall && valid_q && is_cond && !taken ##1 run_i [*2]
        |-> !valid_q && ir_pc_q == $past(pc_q))
        else $error("not-taken branch did not idle one slot");
    a_pc_step: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        run_i && phase_q == PH_WRBACK ##1 run_i |-> pc_q == ADDR_W'($past(pc_q) + 9'h001))
        else $error("program counter did not step by one");
endmodule : cog_instruction_pipeline
`default_nettype wire

/* File: verif/hub_model.sv */
`timescale 1ns/1ps
`default_nettype none
module hub_model
    import cog_pipe_pkg::*;
(
    input wire logic clock_i,
    input wire hub_req_t hub_req_i,
    output logic [DATA_W-1:0] hub_rdata_o
);
    logic [1:0] beat_q;

    initial begin
        hub_rdata_o = 32'h0000_0000;
        beat_q = 2'h0;
    end

    always @(posedge clock_i) begin
        beat_q <= hub_req_i.valid ? beat_q + 2'h1 : 2'h0;
    end

    // Word shows only on the fourth beat; toggling elsewhere exposes an early or late sample
    always @(posedge clock_i) begin
        if (hub_req_i.valid && beat_q == 2'h2) begin
            hub_rdata_o <= {16'hC0DE, hub_req_i.addr[15:0]};
        end else begin
            hub_rdata_o <= ~hub_rdata_o;
        end
    end
endmodule : hub_model
`default_nettype wire

/* File: verif/cog_instruction_pipeline_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module cog_instruction_pipeline_tb
    import cog_pipe_pkg::*;
;
    typedef struct packed {
        op_t op;
        logic imm;
        logic wr;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] exp;
    } case_row_t;

    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic run_i = 1'b0;
    load_t load_i = '0;
    logic [DATA_W-1:0] hub_rdata;
    hub_req_t hub_req;
    logic [ADDR_W-1:0] pc;
    hub_req_t r;
    int bad_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    int t;
    int t2;
    int w;
    case_row_t rows [9] = '{
        '{OP_MOV, 1'b1, 1'b1, 32'hFFFF_FFFF, 32'h0000_01FF, 32'h0000_01FF},
        '{OP_ADD, 1'b0, 1'b1, 32'hFFFF_FFFF, 32'h0000_0002, 32'h0000_0001},
        '{OP_SUB, 1'b1, 1'b1, 32'h0000_0010, 32'h0000_0003, 32'h0000_000D},
        '{OP_AND, 1'b0, 1'b1, 32'hF0F0_F0F0, 32'h0FF0_0FF0, 32'h00F0_00F0},
        '{OP_OR, 1'b1, 1'b1, 32'h1000_0000, 32'h0000_000F, 32'h1000_000F},
        '{OP_MOVE_INTO_OPCODE_FIELD, 1'b1, 1'b1, 32'h0012_3456, 32'h0000_01FF, 32'hFF92_3456},
        '{OP_MOVE_INTO_SOURCE_FIELD, 1'b1, 1'b1, 32'hAAAA_AAAA, 32'h0000_0055, 32'hAAAA_AA55},
        '{OP_MOVE_INTO_DESTINATION_FIELD, 1'b1, 1'b1, 32'hAAAA_AAAA, 32'h0000_00F0, 32'hAAA9_E0AA},
        '{OP_ADD, 1'b1, 1'b0, 32'h0000_0010, 32'h0000_0003, 32'h0000_0010}
    };

    always #4 clock_i = ~clock_i;
    always @(posedge clock_i) cyc <= cyc + 1;

    cog_instruction_pipeline #(.CORE_SLOT(4'h0)) i_cog_instruction_pipeline (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .run_i(run_i), .load_i(load_i),
        .hub_rdata_i(hub_rdata), .hub_req_o(hub_req), .pc_o(pc)
    );
    hub_model i_hub_model (.clock_i(clock_i), .hub_req_i(hub_req), .hub_rdata_o(hub_rdata));

    function automatic logic [31:0] ins(input op_t op, input logic imm, input logic wr,
        input logic [8:0] dst, input logic [8:0] src);
        ins = {op, imm, wr, 6'h00, dst, src};
    endfunction : ins

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_word

    // Loader words only land while the core is held
    task automatic put(input logic [8:0] a, input logic [31:0] d);
        @(posedge clock_i);
        run_i <= 1'b0;
        load_i <= '{we: 1'b1, addr: a, data: d};
    endtask : put

    task automatic start();
        @(posedge clock_i);
        load_i <= '0;
        run_i <= 1'b1;
    endtask : start

    task automatic wait_pc(input logic [8:0] p, output int tc);
        int n;
        n = 0;
        while (pc !== p && n < 100) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        if (n >= 100) begin
            bad_count++;
        end
        tc = cyc;
    endtask : wait_pc

    task automatic wait_hub(output hub_req_t q, output int tr, output int wd);
        int n;
        n = 0;
        wd = 0;
        while (hub_req.valid !== 1'b1 && n < 100) begin
            @(posedge clock_i);
            #1;
            n++;
        end
        tr = cyc;
        q = hub_req;
        while (hub_req.valid === 1'b1 && wd < 20) begin
            @(posedge clock_i);
            #1;
            wd++;
        end
        if (n >= 100 || wd >= 20) begin
            bad_count++;
        end
    endtask : wait_hub

    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    initial begin
        repeat (20000) @(posedge clock_i);
        bad_count++;
        summarize();
    end

    initial begin
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        #1;
        check_word({22'h0, hub_req.valid, pc}, 32'h0000_0000);
        $display("test reset done");
        foreach (rows[i]) begin
            put(9'h064, rows[i].a);
            put(9'h065, rows[i].b);
            put(9'h000, ins(rows[i].op, rows[i].imm, rows[i].wr, 9'h064, rows[i].imm ? rows[i].b[8:0] : 9'h065));
            put(9'h001, ins(OP_HUB_WRITE, 1'b1, 1'b0, 9'h064, 9'h1F0));
            put(9'h002, ins(OP_JUMP_UNCONDITIONAL, 1'b1, 1'b0, 9'h000, 9'h002));
            start();
            wait_hub(r, t, w);
            check_word(r.addr, 32'h0000_01F0);
            check_word(r.wdata, rows[i].exp);
        end
        $display("test rows done");
        // The step after each write-back marks a slot boundary, so their spacing is the slot length
        put(9'h064, 32'hFFFF_FE00);
        put(9'h000, ins(OP_MOV, 1'b1, 1'b0, 9'h064, 9'h000));
        put(9'h001, ins(OP_JUMP_WITH_LINK, 1'b1, 1'b1, 9'h064, 9'h005));
        put(9'h005, ins(OP_MOV, 1'b1, 1'b0, 9'h064, 9'h000));
        put(9'h006, ins(OP_HUB_WRITE, 1'b1, 1'b0, 9'h064, 9'h1F0));
        put(9'h007, ins(OP_JUMP_UNCONDITIONAL, 1'b1, 1'b0, 9'h000, 9'h007));
        start();
        wait_pc(9'h001, t);
        wait_pc(9'h002, t2);
        wait_pc(9'h006, w);
        check_word(32'(t2 - t), 32'h0000_0004);
        check_word(32'(w - t2), 32'h0000_0004);
        wait_hub(r, t, w);
        check_word(r.wdata, 32'hFFFF_FE02);
        $display("test cadence done");
        for (int k = 1; k <= 2; k++) begin
            put(9'h064, 32'(k));
            put(9'h000, ins(OP_DECREMENT_BRANCH_NONZERO, 1'b1, 1'b1, 9'h064, 9'h008));
            put(9'h001, ins(OP_HUB_WRITE, 1'b1, 1'b0, 9'h064, 9'h1F0));
            put(9'h002, ins(OP_JUMP_UNCONDITIONAL, 1'b1, 1'b0, 9'h000, 9'h002));
            put(9'h008, ins(OP_HUB_WRITE, 1'b1, 1'b0, 9'h064, 9'h0AA));
            put(9'h009, ins(OP_JUMP_UNCONDITIONAL, 1'b1, 1'b0, 9'h000, 9'h009));
            start();
            wait_hub(r, t, w);
            check_word(r.addr, k == 1 ? 32'h0000_01F0 : 32'h0000_00AA);
            check_word(r.wdata, 32'(k - 1));
        end
        $display("test branch done");
        put(9'h064, 32'h0000_0055);
        put(9'h000, ins(OP_MOVE_INTO_SOURCE_FIELD, 1'b1, 1'b1, 9'h001, 9'h0AA));
        put(9'h001, ins(OP_HUB_WRITE, 1'b1, 1'b0, 9'h064, 9'h1F0));
        put(9'h002, ins(OP_JUMP_UNCONDITIONAL, 1'b1, 1'b0, 9'h000, 9'h000));
        start();
        wait_hub(r, t, w);
        check_word(r.addr, 32'h0000_01F0);
        wait_hub(r, t, w);
        check_word(r.addr, 32'h0000_00AA);
        $display("test self modify done");
        put(9'h000, ins(OP_HUB_READ, 1'b1, 1'b1, 9'h064, 9'h040));
        put(9'h001, ins(OP_HUB_WRITE, 1'b1, 1'b0, 9'h064, 9'h1F0));
        put(9'h002, ins(OP_JUMP_UNCONDITIONAL, 1'b1, 1'b0, 9'h000, 9'h002));
        start();
        wait_hub(r, t, w);
        check_word({r.we, r.addr[30:0]}, 32'h0000_0040);
        check_word(32'(w), 32'h0000_0004);
        wait_hub(r, t2, w);
        check_word(32'(t2 - t), 32'h0000_0010);
        check_word(r.wdata, 32'hC0DE_0040);
        $display("test hub done");
        // Mid-run reset while the core spins at address two
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        @(posedge clock_i);
        #1;
        check_word({22'h0, hub_req.valid, pc}, 32'h0000_0000);
        @(posedge clock_i);
        rst_n_i <= 1'b1;
        // The program survives reset, so the core restarts at the hub read in word zero
        wait_hub(r, t, w);
        check_word(r.addr, 32'h0000_0040);
        $display("test late reset done");
        summarize();
    end
endmodule : cog_instruction_pipeline_tb
`default_nettype wire
